// *** acc_adc_control.sv ***
// adc option register and conversion sequencer for the charger monitoring adc
`timescale 1ns/100ps
module acc_adc_control #(
   parameter int CHAN_CYCLES = acc_pkg::ACC_CHAN_CYCLES,
   parameter int PERIOD_CYCLES = acc_pkg::ACC_PERIOD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic low_power_i,
   output logic conv_active_o,
   output logic conv_start_o,
   output logic [2:0] conv_channel_o,
   input wire logic conv_done_i,
   output logic result_update_o,
   output logic [2:0] result_channel_o,
   output logic aux_range_select_o,
   output logic set_done_o
);
   import acc_pkg::*;

   localparam int PW = $clog2(PERIOD_CYCLES + 1);

   initial
   begin
      if (PERIOD_CYCLES < CHAN_CYCLES * ACC_NUM_CHANNELS)
      begin
         $error("PERIOD_CYCLES must cover a full set of channels");
      end
   end

   typedef enum logic [3:0]
   {
      ACC_ST_IDLE = 4'b0001,
      ACC_ST_PICK = 4'b0010,
      ACC_ST_CONV = 4'b0100,
      ACC_ST_WAIT = 4'b1000
   } acc_state_type;

   acc_state_type state_reg;
   logic [15:0] option_reg;
   logic [2:0] chan_reg;
   logic [PW-1:0] period_reg;
   logic start_pulse_reg;
   logic update_reg;
   logic set_done_reg;
   logic [2:0] result_chan_reg;
   logic [2:0] lp_sync_reg;
   logic lp_state_reg;
   logic timer_busy;
   logic timer_done;
   logic conv_finish;
   logic set_last;
   logic [7:0] chan_en;
   logic hw_clear_start;

   assign chan_en = option_reg[ACC_CHAN_MSB:ACC_CHAN_LSB];

   // low power pin is asynchronous: three stages, change taken when 2nd and 3rd agree
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lp_sync_reg <= 3'h0;
         lp_state_reg <= 1'b0;
      end
      else
      begin
         lp_sync_reg <= {lp_sync_reg[1:0], low_power_i};
         if (lp_sync_reg[1] == lp_sync_reg[2])
         begin
            lp_state_reg <= lp_sync_reg[2];
         end
      end
   end

   // last enabled channel at or after the current one, in fixed order
   function automatic logic is_last(input logic [7:0] en, input logic [2:0] cur);
      logic r;
      r = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         if (i > int'(cur) && en[i])
         begin
            r = 1'b0;
         end
      end
      return r;
   endfunction : is_last

   assign set_last = is_last(chan_en, chan_reg);
   assign hw_clear_start = conv_finish && set_last && !option_reg[ACC_BIT_REPEAT];

   // option register: host writes, hardware clears start after a one-shot set
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         option_reg <= ACC_OPTION_RESET;
      end
      else
      begin
         if (hw_clear_start)
         begin
            option_reg[ACC_BIT_START] <= 1'b0;
         end
         if (reg_wr_i && reg_addr_i == ACC_REG_OPTION_LO)
         begin
            option_reg[7:0] <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == ACC_REG_OPTION_HI)
         begin
            // reserved bits are kept at zero
            option_reg[15:13] <= reg_wdata_i[7:5];
            option_reg[ACC_RSVD_MSB:ACC_RSVD_LSB] <= 5'h00;
         end
      end
   end

   always_comb
   begin
      reg_rdata_o = 8'h00;
      if (reg_addr_i == ACC_REG_OPTION_LO)
      begin
         reg_rdata_o = option_reg[7:0];
      end
      else if (reg_addr_i == ACC_REG_OPTION_HI)
      begin
         reg_rdata_o = option_reg[15:8];
      end
   end

   assign conv_finish = (state_reg == ACC_ST_CONV) && timer_done && !lp_state_reg;

   // sequencer: walks enabled channels lowest index first
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg <= ACC_ST_IDLE;
         chan_reg <= 3'h0;
         period_reg <= '0;
         start_pulse_reg <= 1'b0;
         update_reg <= 1'b0;
         set_done_reg <= 1'b0;
         result_chan_reg <= 3'h0;
      end
      else
      begin
         start_pulse_reg <= 1'b0;
         update_reg <= 1'b0;
         set_done_reg <= 1'b0;
         if (period_reg != '0)
         begin
            period_reg <= period_reg - 1'b1;
         end
         if (lp_state_reg)
         begin
            state_reg <= ACC_ST_IDLE;
         end
         else
         begin
            unique case (state_reg)
               ACC_ST_IDLE:
               begin
                  if (option_reg[ACC_BIT_START] && chan_en != 8'h00)
                  begin
                     chan_reg <= 3'h0;
                     period_reg <= PW'(PERIOD_CYCLES - 1);
                     state_reg <= ACC_ST_PICK;
                  end
               end
               ACC_ST_PICK:
               begin
                  if (chan_en == 8'h00)
                  begin
                     state_reg <= ACC_ST_IDLE;
                  end
                  else if (chan_en[chan_reg])
                  begin
                     start_pulse_reg <= 1'b1;
                     state_reg <= ACC_ST_CONV;
                  end
                  else
                  begin
                     chan_reg <= chan_reg + 3'h1;
                  end
               end
               ACC_ST_CONV:
               begin
                  if (timer_done)
                  begin
                     update_reg <= 1'b1;
                     result_chan_reg <= chan_reg;
                     if (set_last)
                     begin
                        set_done_reg <= 1'b1;
                        // one-shot ends, continuous waits for the period
                        state_reg <= option_reg[ACC_BIT_REPEAT] ? ACC_ST_WAIT : ACC_ST_IDLE;
                     end
                     else
                     begin
                        chan_reg <= chan_reg + 3'h1;
                        state_reg <= ACC_ST_PICK;
                     end
                  end
               end
               ACC_ST_WAIT:
               begin
                  // host clearing start ends repetition after the finished set
                  if (!option_reg[ACC_BIT_START] || !option_reg[ACC_BIT_REPEAT])
                  begin
                     state_reg <= ACC_ST_IDLE;
                  end
                  else if (period_reg == '0)
                  begin
                     chan_reg <= 3'h0;
                     period_reg <= PW'(PERIOD_CYCLES - 1);
                     state_reg <= ACC_ST_PICK;
                  end
               end
               default:
               begin
                  state_reg <= ACC_ST_IDLE;
               end
            endcase
         end
      end
   end

   acc_channel_timer #(
      .CHAN_CYCLES(CHAN_CYCLES)
   ) u_timer (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .start_i(start_pulse_reg),
      .abort_i(lp_state_reg),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   assign conv_active_o = timer_busy;
   assign conv_start_o = start_pulse_reg;
   assign conv_channel_o = chan_reg;
   assign result_update_o = update_reg;
   assign result_channel_o = result_chan_reg;
   // range only scales system power and comparator input
   assign aux_range_select_o = option_reg[ACC_BIT_RANGE];
   assign set_done_o = set_done_reg;

   sequence s_one_shot_end;
      set_done_reg && !option_reg[ACC_BIT_REPEAT];
   endsequence

   AST_LP_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      lp_state_reg |=> !start_pulse_reg)
      else $error("conversion started in low power mode");
   AST_ONESHOT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_one_shot_end |-> !option_reg[ACC_BIT_START] || $past(reg_wr_i))
      else $error("start bit not cleared after one-shot set");
   AST_ONESHOT_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_one_shot_end |-> state_reg == ACC_ST_IDLE)
      else $error("one-shot set did not stop");
   AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      option_reg[ACC_RSVD_MSB:ACC_RSVD_LSB] == 5'h00)
      else $error("reserved bits not zero");
   AST_ORDER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (update_reg && !set_done_reg) |-> chan_reg > result_chan_reg)
      else $error("channel order broken");
   AST_EN_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      start_pulse_reg |-> chan_en[chan_reg])
      else $error("disabled channel converted");
   AST_CONT_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (set_done_reg && option_reg[ACC_BIT_REPEAT] && !$past(reg_wr_i)) |-> option_reg[ACC_BIT_START]
      || $past(!option_reg[ACC_BIT_START]))
      else $error("start cleared in continuous mode");
   AST_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      aux_range_select_o == option_reg[ACC_BIT_RANGE])
      else $error("range select output wrong");
   AST_PERIOD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ACC_ST_WAIT && period_reg != '0 && option_reg[ACC_BIT_START] && option_reg[ACC_BIT_REPEAT]
      && !lp_state_reg) |=> state_reg != ACC_ST_PICK)
      else $error("set restarted before period elapsed");
endmodule : acc_adc_control

// *** acc_pkg.sv ***
// package: register map, field positions, reset values and timing counts for the adc conversion control
package acc_pkg;
   localparam int ACC_NUM_CHANNELS = 8;
   localparam logic [7:0] ACC_REG_OPTION_LO = 8'h3A;
   localparam logic [7:0] ACC_REG_OPTION_HI = 8'h3B;
   localparam logic [15:0] ACC_OPTION_RESET = 16'h2000;
   localparam int ACC_BIT_REPEAT = 15;
   localparam int ACC_BIT_START = 14;
   localparam int ACC_BIT_RANGE = 13;
   localparam int ACC_RSVD_MSB = 12;
   localparam int ACC_RSVD_LSB = 8;
   localparam int ACC_CHAN_MSB = 7;
   localparam int ACC_CHAN_LSB = 0;
   localparam logic [11:0] ACC_RANGE_LO_FS_MV = 12'h7F8;
   localparam logic [11:0] ACC_RANGE_HI_FS_MV = 12'hBF4;
   localparam int ACC_CLK_HZ = 125000000;
   localparam int ACC_CHAN_TIME_MS = 25;
   localparam int ACC_PERIOD_MS = 1000;
   localparam int ACC_CHAN_CYCLES = ACC_CLK_HZ / 1000 * ACC_CHAN_TIME_MS;
   localparam int ACC_PERIOD_CYCLES = ACC_CLK_HZ / 1000 * ACC_PERIOD_MS;

   typedef enum logic [2:0]
   {
      ACC_CHAN_VBATT = 3'h0,
      ACC_CHAN_SYSV = 3'h1,
      ACC_CHAN_CHG = 3'h2,
      ACC_CHAN_DCHG = 3'h3,
      ACC_CHAN_INCUR = 3'h4,
      ACC_CHAN_SYSPWR = 3'h5,
      ACC_CHAN_BUSV = 3'h6,
      ACC_CHAN_CMP = 3'h7
   } acc_chan_type;

   function automatic logic [3:0] acc_count_ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction : acc_count_ones
endpackage : acc_pkg

// *** acc_channel_timer.sv ***
// per-channel conversion timer: counts a fixed conversion time per started channel
`timescale 1ns/100ps
module acc_channel_timer #(
   parameter int CHAN_CYCLES = acc_pkg::ACC_CHAN_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic abort_i,
   output logic busy_o,
   output logic done_o
);
   import acc_pkg::*;

   localparam int CW = $clog2(CHAN_CYCLES + 1);

   initial
   begin
      if (CHAN_CYCLES < 1)
      begin
         $error("CHAN_CYCLES must be at least 1");
      end
   end

   logic [CW-1:0] count_reg;
   logic busy_reg;
   logic done_reg;

   // never longer than the per-channel maximum
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (abort_i)
         begin
            busy_reg <= 1'b0;
         end
         else if (start_i && !busy_reg)
         begin
            busy_reg <= 1'b1;
            count_reg <= CW'(CHAN_CYCLES - 1);
         end
         else if (busy_reg)
         begin
            if (count_reg == '0)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            else
            begin
               count_reg <= count_reg - 1'b1;
            end
         end
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;

   AST_CHAN_TIME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (start_i && !busy_reg && !abort_i) |=> busy_reg [*1] ##0 (busy_reg || done_reg))
      else $error("channel timer did not start");
endmodule : acc_channel_timer

// *** acc_host_model.sv ***
// host model: byte writes and reads of the option register and low power control
`timescale 1ns/100ps
module acc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   output logic reg_wr_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic low_power_o
);
   initial
   begin
      reg_wr_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      low_power_o = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      // released data must not keep showing the last byte
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      reg_addr_o <= a;
      @(negedge clk_i);
      v = reg_rdata_i;
   endtask : rd

   task automatic set_low_power(input logic on);
      @(posedge clk_i);
      low_power_o <= on;
      // give the input synchroniser time to pass the level
      repeat (6) @(posedge clk_i);
   endtask : set_low_power
endmodule : acc_host_model

// *** test_acc_adc_control.sv ***
// self-checking bench for the adc option register and conversion sequencer
`timescale 1ns/100ps
module test_acc_adc_control;
   import acc_pkg::*;
   localparam int CHAN = 10;
   localparam int PERIOD = 100;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reg_wr, low_power, conv_active, conv_start, result_update, aux_range, set_done;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, mask, v;
   logic [2:0] conv_channel, result_channel;
   logic [2:0] exp_q[$];
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int t_start = 0;
   int n_starts = 0;
   int t_a;
   int t_b;
   int seed = 41096;
   logic start_seen = 1'b0;

   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   acc_adc_control #(.CHAN_CYCLES(CHAN), .PERIOD_CYCLES(PERIOD)) i_acc_adc_control (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .low_power_i(low_power),
      .conv_active_o(conv_active), .conv_start_o(conv_start), .conv_channel_o(conv_channel),
      .conv_done_i(1'b0), .result_update_o(result_update), .result_channel_o(result_channel),
      .aux_range_select_o(aux_range), .set_done_o(set_done));

   acc_host_model i_acc_host_model (
      .clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .low_power_o(low_power));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // monitor: every update must match the oldest expected channel
   always @(negedge clk_i)
   begin
      if (start_seen)
         check("active after start", {15'h0, conv_active}, 16'h0001);
      start_seen = (conv_start === 1'b1);
      if (conv_start === 1'b1)
      begin
         t_start = cyc;
         n_starts++;
         if (exp_q.size() > 0)
            check("start channel", {13'h0, conv_channel}, {13'h0, exp_q[0]});
         else
            check("extra start", 16'h0001, 16'h0000);
      end
      if (result_update === 1'b1)
      begin
         // timer loads one edge after the start pulse, update is registered one edge after done
         check("update spacing", 16'(cyc - t_start), 16'(CHAN + 2));
         if (exp_q.size() == 0)
            check("extra update", 16'h0001, 16'h0000);
         else
            check("result channel", {13'h0, result_channel}, {13'h0, exp_q.pop_front()});
      end
   end

   task automatic wait_done(output int t);
      int k;
      k = 0;
      while (set_done !== 1'b1 && k < 2000)
      begin
         @(negedge clk_i);
         k++;
      end
      check("set done", {15'h0, set_done}, 16'h0001);
      t = cyc;
      @(negedge clk_i);
   endtask : wait_done

   task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
      i_acc_host_model.rd(a, v);
      check(what, {8'h00, v}, {8'h00, exp});
   endtask : rd_check

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_check("option high reset", ACC_REG_OPTION_HI, ACC_OPTION_RESET[15:8]);
      rd_check("option low reset", ACC_REG_OPTION_LO, ACC_OPTION_RESET[7:0]);
      check("range reset", {15'h0, aux_range}, 16'h0001);
      i_acc_host_model.wr(8'h3C, 8'hFF);
      rd_check("unmapped read", 8'h3C, 8'h00);
      rd_check("low after unmapped write", ACC_REG_OPTION_LO, 8'h00);
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'h1F);
      rd_check("reserved bits", ACC_REG_OPTION_HI, 8'h00);
      check("range low", {15'h0, aux_range}, 16'h0000);
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'h20);
      // one-shot set on a random channel mask
      mask = 8'($random(seed)) | 8'h10;
      for (int i = 0; i < ACC_NUM_CHANNELS; i++)
         if (mask[i])
            exp_q.push_back(3'(i));
      i_acc_host_model.wr(ACC_REG_OPTION_LO, mask);
      rd_check("enables", ACC_REG_OPTION_LO, mask);
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'h60);
      wait_done(t_a);
      rd_check("start self clear", ACC_REG_OPTION_HI, 8'h20);
      repeat (300) @(negedge clk_i);
      check("one set only", 16'(exp_q.size()), 16'h0000);
      // continuous sets, then stop
      repeat (2)
      begin
         exp_q.push_back(ACC_CHAN_VBATT);
         exp_q.push_back(ACC_CHAN_CMP);
      end
      i_acc_host_model.wr(ACC_REG_OPTION_LO, 8'h81);
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'hE0);
      wait_done(t_a);
      rd_check("start held", ACC_REG_OPTION_HI, 8'hE0);
      wait_done(t_b);
      check("set period", 16'(t_b - t_a), 16'(PERIOD));
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'hA0);
      repeat (300) @(negedge clk_i);
      check("stop after clear", 16'(exp_q.size()), 16'h0000);
      // low power holds the converter off despite start
      i_acc_host_model.set_low_power(1'b1);
      t_a = n_starts;
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'h60);
      repeat (200) @(negedge clk_i);
      check("low power starts", 16'(n_starts - t_a), 16'h0000);
      check("low power active", {15'h0, conv_active}, 16'h0000);
      i_acc_host_model.wr(ACC_REG_OPTION_HI, 8'h20);
      i_acc_host_model.set_low_power(1'b0);
      repeat (50) @(negedge clk_i);
      check("no late starts", 16'(n_starts - t_a), 16'h0000);
      complete_run();
   end

   // whole sequence needs about 1100 cycles; allow ample margin
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      complete_run();
   end
endmodule : test_acc_adc_control
